// file: shared/mpms_cfg.svh
// Purpose: constants for the multi-purpose pin mode selector
// Assumes: included by the design file
// Notes: offsets are register addresses, input bit numbers are general input indices, the mode bit number is a register bit
`ifndef MPMS_CFG_SVH
`define MPMS_CFG_SVH
`define MPMS_MODE_REG_ADDR 8'h04
`define MPMS_INEN_REG_ADDR 8'h06
`define MPMS_INEN_RESET 8'hff
`define MPMS_MODE_BIT 0
`define MPMS_PIN_HIGH 2'b01
`define MPMS_PIN_LOW 2'b00
`define MPMS_PIN_FLOAT 2'b10
`define MPMS_IN_SUSP 3
`define MPMS_IN_REFSEL 5
`define MPMS_CFG_ZERO 2'b00
`endif

// file: shared/mpms_pkg.sv
// Purpose: types for the multi-purpose pin mode selector
// Assumes: mpms_cfg.svh holds the numbers
// Notes: none
package mpms_pkg;
    typedef enum logic [1:0] {
        MPMS_PLL0_ONLY = 2'b00,
        MPMS_ALL_PLL = 2'b01,
        MPMS_TWO_WIRE = 2'b10,
        MPMS_SCAN = 2'b11
    } mpms_mode_t;
    typedef struct packed {
        logic [2:0] pll0_index;
        logic [1:0] pll1_index;
        logic [1:0] pll2_index;
        logic pll12_fixed;
    } mpms_select_t;
    typedef struct packed {
        logic data_in;
        logic clk;
        logic mode_sel;
        logic reset_n;
    } mpms_scan_t;
endpackage : mpms_pkg

// file: rtl/mpms_pin_router.sv
// Purpose: mode decode and routing of the six general inputs and two status outputs
// Assumes: register writes arrive as a documented address/data strobe on clk
// Notes: selects are indices only; the configuration store lives elsewhere
//
// Operation
// - pll0-only mode: inputs 2..0 index eight pll0 configurations
// - pll0-only mode: input 3 suspend, input 4 unused, input 5 reference select
// - manual and two-wire modes: status 0 loss of lock, status 1 reference missing
// - pll0-only mode: configs 4..7 borrowed from pll1/pll2, those fixed at config 0
// - each configuration's divider-set bit picks post-divider set, 1 picks second; pll0 configs 4..7 use the bits of configs 0..3
// - each post-divider set keeps its own mode bits
// - floating select pin: mode bit 1 gives pll0-only, 0 gives all-pll mode
// - all-pll mode: input pairs 1:0, 3:2, 5:4 index pll0, pll1, pll2
// - two-wire mode: inputs 0,1,3,5 data, clock, suspend, reference select
// - select pin high enters two-wire programming mode
// - scan mode: inputs become scan signals, status 0 carries scan data out
// - select pin low enters boundary-scan programming mode
// - all-pll mode locks to primary reference, switchover follows primary bit
// - at power-up act as all-pll mode, latching inputs 4..0
// - input 5 never latched; during programming only its index use is forced low
// - programming modes freeze selection except pll2 index bit 1, which clears; only register writes change config
// - outside programming, inputs drive the selection continuously
// - enable bits force disabled inputs low; power-up latch still taken
// - programming functions of inputs 0,1,2,4 ignore enable bits
// - disabled input 3 or 5 makes suspend or reference select inactive
// - suspend is active high and suspends associated outputs
// - manual mode bit lives at address 0x04
// - reference select picks reference input or alternate clock input
`timescale 1ns/1ps
`include "mpms_cfg.svh"
module mpms_pin_router #(
    parameter int NUM_IN = 6,
    parameter int NUM_SETS = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register write port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // pins
    input wire logic [NUM_IN-1:0] multi_in,
    input wire logic [1:0] prog_sel_level,
    output logic status_out_0,
    output logic status_out_1,
    // status sources
    input wire logic loss_of_lock,
    input wire logic ref_missing_flag,
    input wire logic selected_clk_missing,
    input wire logic scan_data_out,
    input wire logic primary_ref_bit,
    // per-configuration divider choice, one bit per set of each pll
    input wire logic [3*NUM_SETS-1:0] postdiv_set_select,
    // routed results
    output mpms_pkg::mpms_mode_t mode,
    output mpms_pkg::mpms_select_t select,
    output mpms_pkg::mpms_scan_t scan,
    output logic serial_data_line,
    output logic serial_clk,
    output logic suspend,
    output logic ref_select_alt,
    output logic [2:0] postdiv_second_set
);
    import mpms_pkg::*;

    logic [NUM_IN-1:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
    logic [1:0] lvl1_reg, lvl2_reg, lvl3_reg, lvl_reg;
    logic manual_select_mode_bit_reg;
    logic [7:0] input_enable_bits_reg;
    logic booted_reg;
    logic refsel_pin;
    mpms_select_t select_reg, select_next;
    mpms_mode_t mode_next;
    logic [NUM_IN-1:0] gated;
    logic prog_mode;

    // three-stage pin sync, free-running through reset so the power-up latch sees real pins
    always_ff @(posedge clk)
    begin
        sync1_reg <= multi_in;
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
    end

    // filtered pin levels; a change counts when stages two and three agree
    always_ff @(posedge clk)
    begin
        if (rst)
            pin_reg <= '0;
        else
            for (int i = 0; i < NUM_IN; i++)
                if (sync2_reg[i] == sync3_reg[i])
                    pin_reg[i] <= sync3_reg[i];
    end

    // same three stages for the three-level select pin, also free-running
    always_ff @(posedge clk)
    begin
        lvl1_reg <= prog_sel_level;
        lvl2_reg <= lvl1_reg;
        lvl3_reg <= lvl2_reg;
    end

    // filtered select level; only a one-cycle all-pll window after reset since stages are already full
    always_ff @(posedge clk)
    begin
        if (rst)
            lvl_reg <= `MPMS_PIN_FLOAT;
        else if (lvl2_reg == lvl3_reg)
            lvl_reg <= lvl3_reg;
    end

    // register writes: mode bit and input enables
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            manual_select_mode_bit_reg <= 1'b0;
            input_enable_bits_reg <= `MPMS_INEN_RESET;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `MPMS_MODE_REG_ADDR)
                manual_select_mode_bit_reg <= reg_wdata[`MPMS_MODE_BIT];
            if (reg_addr == `MPMS_INEN_REG_ADDR)
                input_enable_bits_reg <= reg_wdata;
        end
    end

    // read back of the two registers, unmapped reads zero
    always_comb
    begin
        reg_rdata = 8'h00;
        if (reg_addr == `MPMS_MODE_REG_ADDR)
            reg_rdata = {7'h00, manual_select_mode_bit_reg};
        else if (reg_addr == `MPMS_INEN_REG_ADDR)
            reg_rdata = input_enable_bits_reg;
    end

    // mode decode; reset state acts as the all-pll mode
    always_comb
    begin
        case (lvl_reg)
            `MPMS_PIN_HIGH: mode_next = MPMS_TWO_WIRE;
            `MPMS_PIN_LOW: mode_next = MPMS_SCAN;
            default: mode_next = manual_select_mode_bit_reg ? MPMS_PLL0_ONLY
                                                             : MPMS_ALL_PLL;
        endcase
        if (!booted_reg)
            mode_next = MPMS_ALL_PLL;
    end

    assign prog_mode = (mode_next == MPMS_TWO_WIRE) || (mode_next == MPMS_SCAN);

    // clock select keeps working in programming modes; only its index use is forced low
    assign refsel_pin = pin_reg[`MPMS_IN_REFSEL]
        & input_enable_bits_reg[`MPMS_IN_REFSEL];

    // disabled inputs read low; input 5 forced low in programming modes
    always_comb
    begin
        gated = pin_reg & input_enable_bits_reg[NUM_IN-1:0];
        if (prog_mode)
            gated[`MPMS_IN_REFSEL] = 1'b0;
    end

    // power-up latch point: first edge where pins and select level are both steady
    always_ff @(posedge clk)
    begin
        if (rst)
            booted_reg <= 1'b0;
        else if (!booted_reg && sync2_reg == sync3_reg && lvl2_reg == lvl3_reg)
            booted_reg <= 1'b1;
    end

    // selection indices: live outside programming, frozen inside except pll2 index bit 1, which clears
    always_comb
    begin
        select_next = select_reg;
        if (!booted_reg)
        begin
            // latched pins 4..0 taken ignoring enables, input 5 never latched
            select_next.pll0_index = {1'b0, sync3_reg[1:0]};
            select_next.pll1_index = sync3_reg[3:2];
            select_next.pll2_index = {1'b0, sync3_reg[4]};
            select_next.pll12_fixed = 1'b0;
        end
        else if (mode_next == MPMS_PLL0_ONLY)
        begin
            select_next.pll0_index = gated[2:0];
            select_next.pll1_index = `MPMS_CFG_ZERO;
            select_next.pll2_index = `MPMS_CFG_ZERO;
            select_next.pll12_fixed = 1'b1;
        end
        else if (mode_next == MPMS_ALL_PLL)
        begin
            select_next.pll0_index = {1'b0, gated[1:0]};
            select_next.pll1_index = gated[3:2];
            select_next.pll2_index = gated[5:4];
            select_next.pll12_fixed = 1'b0;
        end
        else
        begin
            select_next.pll2_index = {1'b0, select_reg.pll2_index[0]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            select_reg <= '0;
        else
            select_reg <= select_next;
    end

    // registered mode and routed pin functions
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode <= MPMS_ALL_PLL;
            scan <= '0;
            serial_data_line <= 1'b0;
            serial_clk <= 1'b0;
            suspend <= 1'b0;
            ref_select_alt <= 1'b0;
        end
        else
        begin
            mode <= mode_next;
            // programming functions bypass the enable bits
            scan <= (mode_next == MPMS_SCAN) ? {pin_reg[0], pin_reg[1], pin_reg[2],
                                                pin_reg[4]} : '0;
            serial_data_line <= (mode_next == MPMS_TWO_WIRE) && pin_reg[0];
            serial_clk <= (mode_next == MPMS_TWO_WIRE) && pin_reg[1];
            // suspend active high on input 3, except in all-pll mode
            suspend <= (mode_next != MPMS_ALL_PLL) && gated[`MPMS_IN_SUSP];
            // all-pll mode uses the primary bit for manual switchover
            ref_select_alt <= (mode_next == MPMS_ALL_PLL) ? primary_ref_bit
                                                          : refsel_pin;
        end
    end

    // status outputs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status_out_0 <= 1'b0;
            status_out_1 <= 1'b0;
        end
        else if (mode_next == MPMS_SCAN)
        begin
            status_out_0 <= scan_data_out;
            status_out_1 <= selected_clk_missing;
        end
        else
        begin
            status_out_0 <= loss_of_lock;
            status_out_1 <= ref_missing_flag;
        end
    end

    // divider-set choice of each pll's active configuration; pll0 configs 4..7 read the bits of configs 0..3
    always_ff @(posedge clk)
    begin
        if (rst)
            postdiv_second_set <= 3'b000;
        else
        begin
            postdiv_second_set[0] <= postdiv_set_select[select_next.pll0_index[1:0]];
            postdiv_second_set[1] <= postdiv_set_select[NUM_SETS + 32'(select_next.pll1_index)];
            postdiv_second_set[2] <= postdiv_set_select[2*NUM_SETS + 32'(select_next.pll2_index)];
        end
    end

    assign select = select_reg;

    a_scan_out_route: assert property (@(posedge clk) disable iff (rst)
        mode_next == MPMS_SCAN |=> status_out_0 == $past(scan_data_out))
        else $error("status 0 not scan data in scan mode");
    a_two_wire_entry: assert property (@(posedge clk) disable iff (rst)
        booted_reg && lvl_reg == `MPMS_PIN_HIGH |=> mode == MPMS_TWO_WIRE)
        else $error("high select pin did not give two-wire mode");
    a_scan_entry: assert property (@(posedge clk) disable iff (rst)
        booted_reg && lvl_reg == `MPMS_PIN_LOW |=> mode == MPMS_SCAN)
        else $error("low select pin did not give scan mode");
    a_prog_freeze: assert property (@(posedge clk) disable iff (rst)
        booted_reg && prog_mode |=> select_reg.pll0_index == $past(select_reg.pll0_index))
        else $error("selection moved in programming mode");
    a_fixed_others: assert property (@(posedge clk) disable iff (rst)
        mode == MPMS_PLL0_ONLY |-> select_reg.pll1_index == 2'b00 && select_reg.pll12_fixed)
        else $error("pll1 not fixed in pll0-only mode");
    a_status_manual: assert property (@(posedge clk) disable iff (rst)
        mode_next != MPMS_SCAN |=> status_out_1 == $past(ref_missing_flag))
        else $error("status 1 not reference missing");
    a_serial_clk: assert property (@(posedge clk) disable iff (rst)
        mode_next != MPMS_TWO_WIRE |=> !serial_clk)
        else $error("serial clock outside two-wire mode");
    a_suspend_gate: assert property (@(posedge clk) disable iff (rst)
        !input_enable_bits_reg[3] |=> !suspend)
        else $error("suspend active while disabled");
    a_refsel_gate: assert property (@(posedge clk) disable iff (rst)
        !input_enable_bits_reg[`MPMS_IN_REFSEL] && mode_next != MPMS_ALL_PLL
        |=> !ref_select_alt)
        else $error("reference select active while disabled");
endmodule : mpms_pin_router

// file: test/mpms_board_model.sv
// Purpose: board side of the pin router: general input pins and select pin
// Assumes: bench hands requests in; pins move at the falling edge only
// Notes: general input pins are held low while the device is in reset; the select pin is not
`timescale 1ns/1ps
module mpms_board_model (
    // clock
    input wire logic clk,
    // requests from the bench
    input wire logic [5:0] pin_req,
    input wire logic [1:0] sel_req,
    input wire logic in_reset,
    // board pins
    output logic [5:0] multi_in,
    output logic [1:0] prog_sel_level
);
    // defined levels from time zero, so nothing unknown reaches the latch
    initial
    begin
        multi_in = 6'h00;
        prog_sel_level = 2'b10;
    end
    // falling edge keeps pin moves clear of the sampling edge
    always @(negedge clk)
    begin
        multi_in <= in_reset ? 6'h00 : pin_req;
        prog_sel_level <= sel_req;
    end
endmodule : mpms_board_model

// file: test/test_multipurpose_pin_mode_select.sv
// Purpose: self-checking bench for the pin router
// Assumes: pin changes settle within eight cycles
// Notes: expected values noted in a queue, compared by a watcher
`timescale 1ns/1ps
module test_multipurpose_pin_mode_select;
    import mpms_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [5:0] pin_req = 6'h00;
    logic [1:0] sel_req = 2'b10;
    logic [5:0] multi_in;
    logic [1:0] prog_sel_level;
    logic [4:0] src = 5'h00;
    logic [11:0] pd_sel = 12'h000;
    logic status_out_0, status_out_1, sdl, sclk, suspend, ref_alt;
    logic [2:0] pd2;
    mpms_mode_t mode;
    mpms_select_t select, snap;
    mpms_scan_t scan;
    logic [7:0] lfsr = 8'h30;
    logic [7:0] obs;
    logic [7:0] exp_q[$];
    string name_q[$];
    event result_ev;
    int error_cnt = 0;
    int samples_checked = 0;

    always #25 clk = ~clk;

    mpms_board_model i_mpms_board_model (.clk(clk), .pin_req(pin_req), .sel_req(sel_req),
        .in_reset(rst), .multi_in(multi_in), .prog_sel_level(prog_sel_level));
    mpms_pin_router i_mpms_pin_router (.clk(clk), .rst(rst), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .multi_in(multi_in), .prog_sel_level(prog_sel_level),
        .status_out_0(status_out_0), .status_out_1(status_out_1),
        .loss_of_lock(src[4]), .ref_missing_flag(src[3]), .selected_clk_missing(src[2]),
        .scan_data_out(src[1]), .primary_ref_bit(src[0]), .postdiv_set_select(pd_sel),
        .mode(mode), .select(select), .scan(scan), .serial_data_line(sdl),
        .serial_clk(sclk), .suspend(suspend), .ref_select_alt(ref_alt),
        .postdiv_second_set(pd2));

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // note the expectation, then show the watcher what the design gives
    task automatic note(string nm, logic [7:0] exp, logic [7:0] seen);
        name_q.push_back(nm);
        exp_q.push_back(exp);
        obs = seen;
        ->result_ev;
        #1;
    endtask : note

    always @(result_ev)
        check(name_q.pop_front(), obs, exp_q.pop_front());

    task automatic final_report();
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    // synchroniser, filter and output stage all done by then
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask : settle

    function automatic logic [7:0] lfsr_step(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_step

    // new random pins, sources and divider bits, applied at the falling edge
    task automatic shake();
        @(negedge clk);
        lfsr = lfsr_step(lfsr);
        pin_req = lfsr[5:0];
        src = lfsr[7:3];
        pd_sel = {lfsr[3:0], ~lfsr};
        settle();
    endtask : shake

    // watchdog sized well beyond the whole sequence
    initial
    begin
        #(50 * 3000);
        error_cnt++;
        final_report();
    end

    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        settle();
        reg_addr = 8'h04;
        #1 note("mode_bit", 8'h00, reg_rdata);
        reg_addr = 8'h06;
        #1 note("enables", 8'hff, reg_rdata);
        note("mode", {6'h00, MPMS_ALL_PLL}, {6'h00, mode});
        wr(8'h11, 8'hff);
        #1 note("unmapped", 8'h00, reg_rdata);
        for (int i = 0; i < 4; i++)
        begin
            shake();
            note("pll0", {6'h00, pin_req[1:0]}, {6'h00, select.pll0_index[1:0]});
            note("pll1", {6'h00, pin_req[3:2]}, {6'h00, select.pll1_index});
            note("pll2", {6'h00, pin_req[5:4]}, {6'h00, select.pll2_index});
            note("postdiv", {5'h00, pd_sel[8 + pin_req[5:4]], pd_sel[4 + pin_req[3:2]],
                pd_sel[pin_req[1:0]]}, {5'h00, pd2});
            note("status", {6'h00, src[4:3]}, {6'h00, status_out_0, status_out_1});
            note("ref_alt", {7'h00, src[0]}, {7'h00, ref_alt});
        end
        wr(8'h04, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            shake();
            note("mode", {6'h00, MPMS_PLL0_ONLY}, {6'h00, mode});
            note("pll0", {5'h00, pin_req[2:0]}, {5'h00, select.pll0_index});
            note("fixed", 8'h10, {3'h0, select.pll12_fixed, select.pll1_index,
                select.pll2_index});
            note("suspend", {7'h00, pin_req[3]}, {7'h00, suspend});
            note("ref_alt", {7'h00, pin_req[5]}, {7'h00, ref_alt});
        end
        // inputs 3 and 5 switched off while their pins are high
        wr(8'h06, 8'hd7);
        pin_req = 6'h3f;
        settle();
        note("susp_off", 8'h00, {6'h00, suspend, ref_alt});
        note("pll0", 8'h07, {5'h00, select.pll0_index});
        wr(8'h06, 8'h00);
        sel_req = 2'b01;
        settle();
        note("mode", {6'h00, MPMS_TWO_WIRE}, {6'h00, mode});
        snap = select;
        for (int i = 0; i < 3; i++)
        begin
            shake();
            note("serial", {6'h00, pin_req[1:0]}, {6'h00, sclk, sdl});
            note("frozen", snap, select);
            note("pll2_hi", 8'h00, {7'h00, select.pll2_index[1]});
            note("status", {6'h00, src[4:3]}, {6'h00, status_out_0, status_out_1});
            note("prog_off", 8'h00, {6'h00, suspend, ref_alt});
        end
        wr(8'h06, 8'hff);
        sel_req = 2'b00;
        for (int i = 0; i < 3; i++)
        begin
            shake();
            note("mode", {6'h00, MPMS_SCAN}, {6'h00, mode});
            note("scan", {4'h0, pin_req[0], pin_req[1], pin_req[2], pin_req[4]},
                {4'h0, scan});
            note("status", {6'h00, src[1], src[2]}, {6'h00, status_out_0, status_out_1});
            note("frozen", snap, select);
            note("scan_pins", {6'h00, pin_req[3], pin_req[5]},
                {6'h00, suspend, ref_alt});
        end
        // mid-run reset in scan mode: latch takes the low pins, selection stays frozen
        pin_req = 6'h1a;
        @(negedge clk);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        settle();
        note("mode", {6'h00, MPMS_SCAN}, {6'h00, mode});
        note("latched", 8'h00, select);
        sel_req = 2'b10;
        settle();
        note("mode", {6'h00, MPMS_ALL_PLL}, {6'h00, mode});
        note("live", {1'b0, pin_req[1:0], pin_req[3:2], pin_req[5:4], 1'b0},
            select);
        sel_req = 2'b01;
        settle();
        note("mode", {6'h00, MPMS_TWO_WIRE}, {6'h00, mode});
        note("kept", {1'b0, pin_req[1:0], pin_req[3:2], pin_req[5:4], 1'b0},
            select);
        final_report();
    end
endmodule : test_multipurpose_pin_mode_select
